//--- pesr_recorder.sv
// Precise event sample recorder: counter, replay tagging, record writer, Wishbone slave
`timescale 1ns/1ps
module pesr_recorder
  import pesr_pkg::*;
#(
  parameter int unsigned CNT_W     = 32,
  parameter int unsigned MEM_DEPTH = 256
) (
  input  wire logic                     clk_i,
  input  wire logic                     rst_i,
  input  wire logic                     ce_i,
  input  wire logic                     wb_cyc_i,
  input  wire logic                     wb_stb_i,
  input  wire logic                     wb_we_i,
  input  wire logic [pesr_pkg::ADR_W-1:0]  wb_adr_i,
  input  wire logic [3:0]               wb_sel_i,
  input  wire logic [pesr_pkg::DATA_W-1:0] wb_dat_i,
  output logic      [pesr_pkg::DATA_W-1:0] wb_dat_o,
  output logic                          wb_ack_o,
  input  wire pesr_pkg::pesr_retire_t   retire_i,
  input  wire pesr_pkg::pesr_arch_t     arch_i,
  input  wire logic                     smm_i,
  input  wire logic                     mce_i,
  input  wire logic                     init_i,
  output logic                          pmi_o,
  output logic                          precise_active_o
);
  import pesr_pkg::*;

  localparam int unsigned AW = $clog2(MEM_DEPTH);
  localparam int unsigned WC_W = $clog2(REC_WORDS);

  initial begin
    if (CNT_W < 2 || CNT_W > DATA_W) $error("pesr_recorder: CNT_W out of range");
    if (MEM_DEPTH < REC_WORDS || (1 << AW) != MEM_DEPTH) $error("pesr_recorder: bad MEM_DEPTH");
  end

  function automatic logic [DATA_W-1:0] merge_bytes(input logic [DATA_W-1:0] old_v,
                                                    input logic [DATA_W-1:0] new_v,
                                                    input logic [3:0]        sel);
    logic [DATA_W-1:0] r;
    r = old_v;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) r[b*8 +: 8] = new_v[b*8 +: 8];
    end
    return r;
  endfunction

  // Registers
  logic [DATA_W-1:0] sample_en;
  logic [DATA_W-1:0] replay_sel;
  logic [DATA_W-1:0] cnt_ctrl;
  logic [DATA_W-1:0] evt_sel;
  logic [CNT_W-1:0]  counter;
  logic [CNT_W-1:0]  cnt_reload;
  logic [DATA_W-1:0] store_ptr;
  logic [AW-1:0]     rec_index;
  logic [AW-1:0]     rec_absmax;
  logic [AW-1:0]     rec_thresh;
  logic [AW-1:0]     win_addr;
  pesr_state_t       state;
  logic [WC_W-1:0]   word_cnt;
  logic [REC_WORDS-1:0][DATA_W-1:0] snap;
  logic              bus_pend;
  logic              buf_full;

  // Synchronous clear from both reset and INIT
  wire logic clear_all = rst_i | init_i;

  // Bus decode
  wire logic bus_req  = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire logic bus_wr   = bus_pend & wb_we_i & ~wb_ack_o;
  wire logic wr_sen   = bus_wr & (wb_adr_i == OFS_SAMPLE_EN);
  wire logic wr_rts   = bus_wr & (wb_adr_i == OFS_REPLAY_SEL);
  wire logic wr_ccr   = bus_wr & (wb_adr_i == OFS_CNT_CTRL);
  wire logic wr_esr   = bus_wr & (wb_adr_i == OFS_EVT_SEL);
  wire logic wr_cnt   = bus_wr & (wb_adr_i == OFS_COUNTER);
  wire logic wr_rld   = bus_wr & (wb_adr_i == OFS_CNT_RELOAD);
  wire logic wr_ptr   = bus_wr & (wb_adr_i == OFS_STORE_PTR);
  wire logic wr_idx   = bus_wr & (wb_adr_i == OFS_REC_INDEX);
  wire logic wr_max   = bus_wr & (wb_adr_i == OFS_REC_ABSMAX);
  wire logic wr_thr   = bus_wr & (wb_adr_i == OFS_REC_THRESH);
  wire logic wr_win   = bus_wr & (wb_adr_i == OFS_WIN_ADDR);
  wire logic [DATA_W-1:0] wr_data_ccr = merge_bytes(cnt_ctrl, wb_dat_i, wb_sel_i);
  // Size casts zero-extend and stay legal when CNT_W equals DATA_W
  wire logic [DATA_W-1:0] cnt_wide    = DATA_W'(counter);
  wire logic [DATA_W-1:0] cnt_wr_val  = merge_bytes(cnt_wide, wb_dat_i, wb_sel_i);
  wire logic [DATA_W-1:0] rld_wide    = DATA_W'(cnt_reload);
  wire logic [DATA_W-1:0] rld_wr_val  = merge_bytes(rld_wide, wb_dat_i, wb_sel_i);
  wire logic [DATA_W-1:0] idx_wr_val  = merge_bytes({{(DATA_W-AW){1'b0}}, rec_index}, wb_dat_i, wb_sel_i);
  wire logic [DATA_W-1:0] max_wr_val  = merge_bytes({{(DATA_W-AW){1'b0}}, rec_absmax}, wb_dat_i, wb_sel_i);
  wire logic [DATA_W-1:0] thr_wr_val  = merge_bytes({{(DATA_W-AW){1'b0}}, rec_thresh}, wb_dat_i, wb_sel_i);
  wire logic [DATA_W-1:0] win_wr_val  = merge_bytes({{(DATA_W-AW){1'b0}}, win_addr}, wb_dat_i, wb_sel_i);

  // Event qualification
  wire logic tag_en_bit  = sample_en[SEN_TAG_EN_BIT];
  wire logic my_thr_bit  = sample_en[SEN_MY_THR_BIT];
  wire logic tag_allowed = tag_en_bit | ~(tag_en_bit | my_thr_bit);
  wire logic type_match  = |(retire_i.uop_type & replay_sel[RTS_TYPE_W-1:0]);
  wire logic evt_match   = |(retire_i.replay_ev & sample_en[SEN_EVT_LSB +: SEN_EVT_W]);
  wire logic replay_tag  = tag_allowed & type_match & evt_match;
  wire logic [ESR_EVT_W-1:0] ev_class = evt_sel[ESR_EVT_LSB +: ESR_EVT_W];
  wire logic is_replay   = (ev_class == EVC_REPLAY);
  wire logic is_exec     = (ev_class == EVC_EXECUTION);
  wire logic is_fe       = (ev_class == EVC_FRONT_END);
  wire logic at_retire   = is_replay | is_exec | is_fe;
  wire logic ev_hit      = retire_i.valid & ((is_replay & replay_tag) | (is_exec & retire_i.exec_tag)
                                             | (is_fe & retire_i.fe_tag));
  // Gated by enable bit 24, event class and system management mode; real mode is deliberately no gate
  wire logic precise_ok  = tag_en_bit & at_retire & ~smm_i;
  wire logic cnt_inc     = cnt_ctrl[CCR_EN_BIT] & ev_hit;
  wire logic ovf_evt     = cnt_inc & (&counter);
  wire logic room_left   = (rec_index < rec_absmax);
  wire logic start_rec   = ovf_evt & precise_ok & room_left & (state == ST_IDLE);
  wire logic last_word   = (state == ST_WRITE) & (word_cnt == WC_W'(REC_WORDS - 1));
  wire logic [AW-1:0] next_index = rec_index + AW'(1);
  wire logic [AW-1:0] rec_base   = AW'(rec_index * REC_WORDS);
  wire logic [AW-1:0] mem_waddr  = rec_base + AW'(word_cnt);
  wire logic          mem_we     = (state == ST_WRITE) & ce_i;
  wire logic [DATA_W-1:0] mem_rdata;
  wire logic near_full   = last_word & (next_index >= rec_thresh);
  wire logic np_pmi      = ovf_evt & ~precise_ok & cnt_ctrl[CCR_PMI_BIT];

  // Read mux
  logic [DATA_W-1:0] rd_mux;
  always_comb begin
    rd_mux = RST_ZERO;
    case (wb_adr_i)
      OFS_SAMPLE_EN:  rd_mux = sample_en;
      OFS_REPLAY_SEL: rd_mux = replay_sel;
      OFS_CNT_CTRL:   rd_mux = cnt_ctrl;
      OFS_EVT_SEL:    rd_mux = evt_sel;
      OFS_COUNTER:    rd_mux = cnt_wide;
      OFS_CNT_RELOAD: rd_mux = rld_wide;
      OFS_STORE_PTR:  rd_mux = store_ptr;
      OFS_REC_INDEX:  rd_mux = {{(DATA_W-AW){1'b0}}, rec_index};
      OFS_REC_ABSMAX: rd_mux = {{(DATA_W-AW){1'b0}}, rec_absmax};
      OFS_REC_THRESH: rd_mux = {{(DATA_W-AW){1'b0}}, rec_thresh};
      OFS_WIN_ADDR:   rd_mux = {{(DATA_W-AW){1'b0}}, win_addr};
      OFS_WIN_DATA:   rd_mux = mem_rdata;
      OFS_MISC_FEAT:  rd_mux = RST_ZERO & ~(DATA_W'(1) << MISC_ABSENT_BIT);
      OFS_FEATURE_ID: rd_mux = DATA_W'(1) << FEAT_STORE_BIT;
      OFS_STATUS:     rd_mux = (DATA_W'(state == ST_WRITE) << STAT_BUSY_BIT)
                               | (DATA_W'(buf_full) << STAT_FULL_BIT)
                               | (DATA_W'(precise_ok) << STAT_ACT_BIT);
      default:        rd_mux = RST_ZERO;
    endcase
  end

  // Bus handshake: two wait states, so window data from memory is settled
  always_ff @(posedge clk_i) begin
    if (clear_all) begin
      bus_pend <= 1'b0;
      wb_ack_o <= 1'b0;
      wb_dat_o <= RST_ZERO;
    end else if (ce_i) begin
      bus_pend <= bus_req & ~bus_pend;
      wb_ack_o <= bus_pend & ~wb_ack_o;
      if (bus_pend & ~wb_we_i) begin
        wb_dat_o <= rd_mux;
      end
    end
  end

  // Software configuration registers
  always_ff @(posedge clk_i) begin
    if (clear_all) begin
      sample_en  <= RST_ZERO;
      replay_sel <= RST_ZERO;
      evt_sel    <= RST_ZERO;
      store_ptr  <= RST_ZERO;
      rec_absmax <= AW'(0);
      rec_thresh <= AW'(0);
      win_addr   <= AW'(0);
    end else if (ce_i) begin
      if (mce_i) begin
        sample_en[SEN_TAG_EN_BIT] <= 1'b0;
        sample_en[SEN_MY_THR_BIT] <= 1'b0;
      end else if (wr_sen) begin
        sample_en <= merge_bytes(sample_en, wb_dat_i, wb_sel_i);
      end
      if (wr_rts) replay_sel <= merge_bytes(replay_sel, wb_dat_i, wb_sel_i);
      if (wr_esr) evt_sel <= merge_bytes(evt_sel, wb_dat_i, wb_sel_i);
      if (wr_ptr) store_ptr <= merge_bytes(store_ptr, wb_dat_i, wb_sel_i);
      if (wr_max) rec_absmax <= max_wr_val[AW-1:0];
      if (wr_thr) rec_thresh <= thr_wr_val[AW-1:0];
      if (wr_win) win_addr <= win_wr_val[AW-1:0];
    end
  end

  // Counter control with sticky overflow; a new overflow beats a clearing write
  always_ff @(posedge clk_i) begin
    if (clear_all) begin
      cnt_ctrl <= RST_ZERO;
    end else if (ce_i) begin
      if (wr_ccr) cnt_ctrl <= wr_data_ccr;
      if (ovf_evt) cnt_ctrl[CCR_OVF_BIT] <= 1'b1;
    end
  end

  // Counter and its reload value
  always_ff @(posedge clk_i) begin
    if (clear_all) begin
      counter    <= CNT_W'(0);
      cnt_reload <= CNT_W'(0);
    end else if (ce_i) begin
      if (wr_rld) cnt_reload <= rld_wr_val[CNT_W-1:0];
      if (ovf_evt) begin
        counter <= cnt_reload;
      end else if (cnt_inc) begin
        counter <= counter + CNT_W'(1);
      end else if (wr_cnt) begin
        counter <= cnt_wr_val[CNT_W-1:0];
      end
    end
  end

  // Record writer: snapshot at overflow, one word per cycle afterwards
  always_ff @(posedge clk_i) begin
    if (clear_all) begin
      state     <= ST_IDLE;
      word_cnt  <= WC_W'(0);
      rec_index <= AW'(0);
      buf_full  <= 1'b0;
      snap      <= '0;
    end else if (ce_i) begin
      case (state)
        ST_IDLE: begin
          if (start_rec) begin
            snap     <= arch_i;
            word_cnt <= WC_W'(0);
            state    <= ST_WRITE;
          end else if (wr_idx) begin
            rec_index <= idx_wr_val[AW-1:0];
          end
          buf_full <= ~room_left;
        end
        ST_WRITE: begin
          if (last_word) begin
            rec_index <= next_index;
            buf_full  <= (next_index >= rec_absmax);
            state     <= ST_IDLE;
          end else begin
            word_cnt <= word_cnt + WC_W'(1);
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  // One shared interrupt line for precise and ordinary sampling
  always_ff @(posedge clk_i) begin
    if (clear_all) begin
      pmi_o            <= 1'b0;
      precise_active_o <= 1'b0;
    end else if (ce_i) begin
      pmi_o            <= near_full | np_pmi;
      precise_active_o <= precise_ok;
    end
  end

  pesr_rec_mem #(
    .WIDTH (DATA_W),
    .DEPTH (MEM_DEPTH),
    .AW    (AW)
  ) u_rec_mem (
    .clk_i   (clk_i),
    .ce_i    (ce_i),
    .we_i    (mem_we),
    .waddr_i (mem_waddr),
    .wdata_i (snap[word_cnt]),
    .raddr_i (win_addr),
    .rdata_o (mem_rdata)
  );

endmodule // pesr_recorder

//--- pesr_pkg.sv
// Constants, register map and carrier types of the precise event sample recorder
// Contract
// - Replay tag needs uop type match and replay event match before retirement.
// - Replay tagging runs only while sampling enable bit 24 is set; the code also tags with bits 24 and 25 both clear.
// - With bits 24 and 25 both clear, replay tags feed ordinary sampling.
// - On counter overflow, copy general registers, flags and instruction pointer into a record.
// - After a record, reload the counter with its reset count and keep counting.
// - Raise an interrupt when the record buffer nears full.
// - The record buffer never wraps.
// - Precise sampling only for execution, front-end and replay events.
// - Precise sampling uses exactly one designated counter.
// - Feature flag bit 21 reports the store facility.
// - Sampling-absent flag reads clear because precise sampling exists.
// - Bit 24 of sampling enable turns precise sampling on, clear turns off.
// - A writable store-area pointer register locates the save area; the code only holds it, and records go to the internal record memory.
// - Precise interrupts share the one sampling interrupt output.
// - Store mechanism is off throughout system management mode.
// - Machine check disables the mechanism; reset and INIT clear it.
// - Store mechanism keeps working in real address mode.
// - Overflow sets sticky bit 31 of counter control until software clears it.
package pesr_pkg;

  localparam int unsigned DATA_W = 32;
  localparam int unsigned ADR_W  = 8;
  localparam int unsigned NGPR   = 8;
  localparam int unsigned REC_WORDS = NGPR + 2;

  // Register byte offsets
  localparam logic [ADR_W-1:0] OFS_SAMPLE_EN  = 8'h00;
  localparam logic [ADR_W-1:0] OFS_REPLAY_SEL = 8'h04;
  localparam logic [ADR_W-1:0] OFS_CNT_CTRL   = 8'h08;
  localparam logic [ADR_W-1:0] OFS_EVT_SEL    = 8'h0C;
  localparam logic [ADR_W-1:0] OFS_COUNTER    = 8'h10;
  localparam logic [ADR_W-1:0] OFS_CNT_RELOAD = 8'h14;
  localparam logic [ADR_W-1:0] OFS_STORE_PTR  = 8'h18;
  localparam logic [ADR_W-1:0] OFS_REC_INDEX  = 8'h1C;
  localparam logic [ADR_W-1:0] OFS_REC_ABSMAX = 8'h20;
  localparam logic [ADR_W-1:0] OFS_REC_THRESH = 8'h24;
  localparam logic [ADR_W-1:0] OFS_WIN_ADDR   = 8'h28;
  localparam logic [ADR_W-1:0] OFS_WIN_DATA   = 8'h2C;
  localparam logic [ADR_W-1:0] OFS_MISC_FEAT  = 8'h30;
  localparam logic [ADR_W-1:0] OFS_FEATURE_ID = 8'h34;
  localparam logic [ADR_W-1:0] OFS_STATUS     = 8'h38;

  // Field positions
  localparam int unsigned SEN_TAG_EN_BIT  = 24;
  localparam int unsigned SEN_MY_THR_BIT  = 25;
  localparam int unsigned SEN_EVT_LSB     = 0;
  localparam int unsigned SEN_EVT_W       = 8;
  localparam int unsigned RTS_TYPE_W      = 4;
  localparam int unsigned CCR_EN_BIT      = 12;
  localparam int unsigned CCR_PMI_BIT     = 26;
  localparam int unsigned CCR_OVF_BIT     = 31;
  localparam int unsigned ESR_EVT_LSB     = 25;
  localparam int unsigned ESR_EVT_W       = 6;
  localparam int unsigned FEAT_STORE_BIT  = 21;
  localparam int unsigned MISC_ABSENT_BIT = 12;
  localparam int unsigned STAT_BUSY_BIT   = 0;
  localparam int unsigned STAT_FULL_BIT   = 1;
  localparam int unsigned STAT_ACT_BIT    = 2;

  // Event class codes, arbitrary
  localparam logic [ESR_EVT_W-1:0] EVC_FRONT_END = 6'h08;
  localparam logic [ESR_EVT_W-1:0] EVC_EXECUTION = 6'h0C;
  localparam logic [ESR_EVT_W-1:0] EVC_REPLAY    = 6'h09;

  localparam logic [DATA_W-1:0] RST_ZERO = 32'h0000_0000;

  typedef struct packed {
    logic                  valid;
    logic [RTS_TYPE_W-1:0] uop_type;
    logic [SEN_EVT_W-1:0]  replay_ev;
    logic                  exec_tag;
    logic                  fe_tag;
  } pesr_retire_t;

  typedef struct packed {
    logic [DATA_W-1:0]            ip;
    logic [DATA_W-1:0]            flags;
    logic [NGPR-1:0][DATA_W-1:0]  gpr;
  } pesr_arch_t;

  typedef enum logic {ST_IDLE, ST_WRITE} pesr_state_t;

endpackage

//--- pesr_rec_mem.sv
// Record memory with one write port and one registered read port
`timescale 1ns/1ps
module pesr_rec_mem #(
  parameter int unsigned WIDTH = 32,
  parameter int unsigned DEPTH = 256,
  parameter int unsigned AW    = 8
) (
  input  wire logic             clk_i,
  input  wire logic             ce_i,
  input  wire logic             we_i,
  input  wire logic [AW-1:0]    waddr_i,
  input  wire logic [WIDTH-1:0] wdata_i,
  input  wire logic [AW-1:0]    raddr_i,
  output logic      [WIDTH-1:0] rdata_o
);

  logic [WIDTH-1:0] mem [DEPTH];

  initial begin
    if (DEPTH > (1 << AW)) $error("pesr_rec_mem: DEPTH exceeds address range");
  end

  always_ff @(posedge clk_i) begin
    if (ce_i) begin
      if (we_i) begin
        mem[waddr_i] <= wdata_i;
      end
      rdata_o <= mem[raddr_i];
    end
  end

endmodule // pesr_rec_mem

//--- pesr_recorder_monitor.sv
// Port-level checker for the precise event sample recorder
`timescale 1ns/1ps
module pesr_recorder_monitor (
  input wire logic                         clk_i,
  input wire logic                         rst_i,
  input wire logic                         init_i,
  input wire logic                         mce_i,
  input wire logic                         smm_i,
  input wire logic                         wb_cyc_i,
  input wire logic                         wb_stb_i,
  input wire logic                         wb_we_i,
  input wire logic [pesr_pkg::DATA_W-1:0]  wb_dat_o,
  input wire logic                         wb_ack_o,
  input wire logic                         pmi_o,
  input wire logic                         precise_active_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  a_ack_two_cycles: assert property ($rose(wb_cyc_i && wb_stb_i) |-> !wb_ack_o ##1 !wb_ack_o ##1 wb_ack_o)
    else $error("ack not two cycles after request");
  a_ack_one_cycle: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_ack_needs_req: assert property (wb_ack_o |-> $past(wb_cyc_i) && $past(wb_stb_i))
    else $error("ack without request");
  // Read data only moves on a read answer or a clear
  a_dat_on_read: assert property ($changed(wb_dat_o) |-> (wb_ack_o && !wb_we_i) || $past(init_i))
    else $error("read data changed outside a read");
  a_pmi_single: assert property (pmi_o |=> !pmi_o)
    else $error("interrupt pulse too long");
  a_smm_blocks: assert property (smm_i |=> !precise_active_o)
    else $error("precise sampling active in management mode");
  a_mce_blocks: assert property (mce_i |-> ##2 !precise_active_o)
    else $error("precise sampling survives machine check");
  a_init_clears: assert property (init_i |=> !pmi_o && !wb_ack_o && !precise_active_o)
    else $error("outputs not cleared by init");
endmodule // pesr_recorder_monitor

bind pesr_recorder pesr_recorder_monitor u_mon (
  .clk_i(clk_i), .rst_i(rst_i), .init_i(init_i), .mce_i(mce_i), .smm_i(smm_i),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_dat_o(wb_dat_o),
  .wb_ack_o(wb_ack_o), .pmi_o(pmi_o), .precise_active_o(precise_active_o)
);

//--- pesr_core_model.sv
// Retirement stream, architectural state and interrupt service model
`timescale 1ns/1ps
module pesr_core_model
  import pesr_pkg::*;
(
  input  wire logic              clk_i,
  input  wire logic              pmi_i,
  output pesr_pkg::pesr_retire_t retire_o,
  output pesr_pkg::pesr_arch_t   arch_o
);
  int n_irq;
  logic [7:0] seq = 8'h00;

  // State moves with each retirement, so each record has its own known image
  always_comb begin
    arch_o.ip = 32'h0040_1000 + 32'(seq);
    arch_o.flags = 32'h0000_0246 + 32'(seq);
    for (int k = 0; k < NGPR; k++) begin
      arch_o.gpr[k] = 32'h1000_0000 + (32'(seq) << 8) + 32'(k);
    end
  end

  initial begin
    retire_o = '0;
    n_irq = 0;
  end

  // Interrupt counter: one count per cycle that pmi_i is high
  always @(posedge clk_i) begin
    if (pmi_i === 1'b1) begin
      n_irq <= n_irq + 1;
    end
  end

  // Gap of 15 idle cycles lets a 10-word record finish
  task automatic emit(input int n);
    repeat (n) begin
      @(posedge clk_i);
      retire_o <= '{1'b1, 4'h1, 8'h01, 1'b0, 1'b0};
      seq <= seq + 8'h01;
      @(posedge clk_i);
      retire_o <= '{1'b0, 4'hE, 8'hFE, 1'b1, 1'b1};
      repeat (14) @(posedge clk_i);
    end
  endtask
endmodule // pesr_core_model

//--- testbench.sv
// Self-checking bench for the precise event sample recorder
`timescale 1ns/1ps
module testbench;
  import pesr_pkg::*;
  logic         clk_i = 1'b0;
  logic         rst_i = 1'b1;
  logic         cyc = 1'b0;
  logic         stb = 1'b0;
  logic         we = 1'b0;
  logic [7:0]   adr = 8'h00;
  logic [31:0]  wdat = 32'h0000_0000;
  logic [31:0]  rdat;
  logic         ack;
  logic         pmi;
  logic         act;
  logic         system_management_mode = 1'b0;
  logic         mce = 1'b0;
  logic         init = 1'b0;
  logic         ce = 1'b1;
  logic [3:0]   sel = 4'hF;
  pesr_retire_t ret;
  pesr_arch_t   arch;
  int           n_mismatch = 0;
  int           compares = 0;

  always #5 clk_i = ~clk_i;

  // Narrow counter so overflow comes after a few events
  pesr_recorder #(.CNT_W(8), .MEM_DEPTH(256)) dut (
    .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .retire_i(ret), .arch_i(arch), .smm_i(system_management_mode), .mce_i(mce), .init_i(init),
    .pmi_o(pmi), .precise_active_o(act));

  pesr_core_model u_core (.clk_i(clk_i), .pmi_i(pmi), .retire_o(ret), .arch_o(arch));

  task automatic conclude();
    if (n_mismatch == 0 && compares > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask

  // Waits for ack with no cycle limit; only the watchdog ends a hang
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                     output logic [31:0] q);
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    sel <= s;
    do begin
      @(posedge clk_i);
    end while (ack !== 1'b1);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk_i);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, 4'hF, q);
  endtask

  task automatic wrs(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    logic [31:0] q;
    bus(1'b1, a, d, s, q);
  endtask

  task automatic rc(input logic [7:0] a, input logic [31:0] e, input string nm);
    logic [31:0] q;
    bus(1'b0, a, 32'h0000_0000, 4'hF, q);
    chk(nm, e, q);
  endtask

  task automatic win(input logic [7:0] w, input logic [31:0] e);
    wr(OFS_WIN_ADDR, {24'h00_0000, w});
    rc(OFS_WIN_DATA, e, "window");
  endtask

  initial begin
    #500000;
    n_mismatch++;
    conclude();
  end

  initial begin
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    rc(OFS_MISC_FEAT, 32'h0000_0000, "misc");
    rc(OFS_FEATURE_ID, 32'h0020_0000, "feature");
    wr(8'h3C, 32'hFFFF_FFFF);
    rc(8'h3C, 32'h0000_0000, "unmapped");
    wr(OFS_STORE_PTR, 32'h1234_5678);
    rc(OFS_STORE_PTR, 32'h1234_5678, "store_ptr");
    wrs(OFS_STORE_PTR, 32'hAAAA_AAAA, 4'h5);
    rc(OFS_STORE_PTR, 32'h12AA_56AA, "byte lanes");
    wr(OFS_REC_ABSMAX, 32'h0000_0002);
    wr(OFS_REC_THRESH, 32'h0000_0002);
    wr(OFS_CNT_RELOAD, 32'h0000_00FE);
    wr(OFS_COUNTER, 32'h0000_00FE);
    wr(OFS_SAMPLE_EN, 32'h0100_0001);
    wr(OFS_REPLAY_SEL, 32'h0000_0001);
    wr(OFS_EVT_SEL, 32'h1200_0000);
    wr(OFS_CNT_CTRL, 32'h0000_1000);
    u_core.emit(2);
    rc(OFS_REC_INDEX, 32'h0000_0001, "index");
    rc(OFS_CNT_CTRL, 32'h8000_1000, "sticky");
    chk("active", 32'h0000_0001, {31'h0000_0000, act});
    u_core.emit(2);
    chk("irq", 32'h0000_0001, u_core.n_irq);
    // Third overflow finds the buffer at its limit
    u_core.emit(2);
    rc(OFS_REC_INDEX, 32'h0000_0002, "absmax");
    rc(OFS_STATUS, 32'h0000_0006, "status");
    rc(OFS_COUNTER, 32'h0000_00FE, "reload");
    // Clock enable low: a counted retirement must leave the counter alone
    ce <= 1'b0;
    u_core.emit(1);
    ce <= 1'b1;
    rc(OFS_COUNTER, 32'h0000_00FE, "frozen");
    chk("irq", 32'h0000_0001, u_core.n_irq);
    win(8'h00, 32'h1000_0200);
    win(8'h08, 32'h0000_0248);
    win(8'h09, 32'h0040_1002);
    win(8'h11, 32'h1000_0407);
    wr(OFS_CNT_CTRL, 32'h0000_1000);
    rc(OFS_CNT_CTRL, 32'h0000_1000, "sticky clear");
    wr(OFS_EVT_SEL, 32'h0200_0000);
    u_core.emit(2);
    rc(OFS_COUNTER, 32'h0000_00FE, "other class");
    chk("active", 32'h0000_0000, {31'h0000_0000, act});
    wr(OFS_EVT_SEL, 32'h1200_0000);
    wr(OFS_REPLAY_SEL, 32'h0000_0002);
    u_core.emit(2);
    rc(OFS_COUNTER, 32'h0000_00FE, "uop type");
    wr(OFS_REPLAY_SEL, 32'h0000_0001);
    wr(OFS_SAMPLE_EN, 32'h0200_0001);
    u_core.emit(2);
    rc(OFS_COUNTER, 32'h0000_00FE, "bit25 only");
    wr(OFS_SAMPLE_EN, 32'h0000_0001);
    wr(OFS_CNT_CTRL, 32'h0400_1000);
    u_core.emit(2);
    chk("irq", 32'h0000_0002, u_core.n_irq);
    wr(OFS_SAMPLE_EN, 32'h0100_0001);
    @(posedge clk_i);
    system_management_mode <= 1'b1;
    repeat (3) @(posedge clk_i);
    chk("smm", 32'h0000_0000, {31'h0000_0000, act});
    system_management_mode <= 1'b0;
    repeat (3) @(posedge clk_i);
    chk("active", 32'h0000_0001, {31'h0000_0000, act});
    mce <= 1'b1;
    @(posedge clk_i);
    mce <= 1'b0;
    rc(OFS_SAMPLE_EN, 32'h0000_0001, "mce");
    @(posedge clk_i);
    init <= 1'b1;
    @(posedge clk_i);
    init <= 1'b0;
    rc(OFS_STORE_PTR, 32'h0000_0000, "init");
    rc(OFS_REC_INDEX, 32'h0000_0000, "init");
    conclude();
  end
endmodule // testbench
